// file: src/iomb_alu.sv
// Combinational data path: increment, OR and pass-through.
// Assumes operands are stable for the whole cycle.
`timescale 1ns/1ps

module iomb_alu import iomb_pkg::*; (
    iomb_alu_if.alu a
);

    always_comb begin
        case (a.op)
            IOMB_OP_INCSKIP: a.result = 8'(a.fdata + 8'h01);
            IOMB_OP_INC: a.result = 8'(a.fdata + 8'h01);
            IOMB_OP_ORLIT: a.result = a.acc | a.lit;
            IOMB_OP_ORREG: a.result = a.acc | a.fdata;
            IOMB_OP_MOVE: a.result = a.fdata;
            default: a.result = a.acc;
        endcase
    end

    // Plain zero test of the eight result bits.
    assign a.zero = iomb_is_zero(a.result);

endmodule : iomb_alu

// file: src/iomb_alu_if.sv
// Carrier between the executor and its data path.
// Assumes the executor drives the operands and reads the result.
`timescale 1ns/1ps

interface iomb_alu_if;
    import iomb_pkg::*;
    iomb_op_t op;
    logic [7:0] acc;
    logic [7:0] fdata;
    logic [7:0] lit;
    logic [7:0] result;
    logic zero;
    modport ctl (output op, acc, fdata, lit, input result, zero);
    modport alu (input op, acc, fdata, lit, output result, zero);
endinterface : iomb_alu_if

// file: src/iomb_consts.svh
// Constants for the increment, OR, move and branch execution block.
// Assumes a 14-bit instruction word and an 8-bit data path.
`ifndef IOMB_CONSTS_SVH
`define IOMB_CONSTS_SVH

// Six-bit major opcodes, taken from instruction bits 13 to 8.
`define IOMB_OPC_INCSKIP 6'h0f
`define IOMB_OPC_INC 6'h0a
`define IOMB_OPC_ORREG 6'h04
`define IOMB_OPC_MOVE 6'h08
`define IOMB_OPC_ORLIT 6'h38
// Three-bit opcode of the branch, taken from instruction bits 13 to 11.
`define IOMB_OPC_BRANCH 3'h5

// Field positions inside the instruction word.
`define IOMB_OPC_HI 13
`define IOMB_OPC_LO 8
`define IOMB_BRA_OPC_LO 11
`define IOMB_DEST_BIT 7
`define IOMB_FILE_HI 6
`define IOMB_LIT_HI 7
`define IOMB_TARGET_HI 10

// Page latch bits that feed program counter bits 12 to 11.
`define IOMB_PAGE_HI 4
`define IOMB_PAGE_LO 3

// Reset values and the program counter step.
`define IOMB_ACC_RST 8'h00
`define IOMB_PC_RST 13'h0000
`define IOMB_PC_STEP 13'h0001

`endif

// file: src/iomb_exec.sv
// Executor for increment, skip, branch, OR and move instructions.
// Assumes the file register addressed by instr_word[6:0] is on
// file_rd_data in the same cycle as the instruction.
//
// How it works
// - Increment-skip adds one, flags untouched, d selects
// - Zero result turns next instruction into no-op
// - Branch loads 11-bit target, page bits 4:3
// - Branch takes two cycles, flags untouched
// - OR literal into accumulator, zero flag updated
// - Increment adds one, zero flag, d selects
// - OR accumulator with register, zero flag, d
// - Move register to accumulator or itself
// - Move updates zero flag even to itself
`timescale 1ns/1ps
`include "iomb_consts.svh"

module iomb_exec import iomb_pkg::*; (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire logic [13:0] instr_word,
    input wire logic [7:0] file_rd_data,
    input wire logic [7:0] pc_page_latch,
    output logic [7:0] acc_reg,
    output logic zero_reg,
    output logic [12:0] pc_reg,
    output logic file_wr_en_reg,
    output logic [6:0] file_wr_addr_reg,
    output logic [7:0] file_wr_data_reg,
    output logic slot_nop_reg
);

    iomb_alu_if a ();
    iomb_op_t op;
    logic flush_reg;
    logic flush_hold_pc_reg;
    logic exec;
    logic dest_file;
    logic sets_zero;
    logic [12:0] pc_next;

    iomb_alu u_alu (
        .a(a)
    );

    assign op = iomb_decode(instr_word);
    // A slot behind a taken skip or a branch is consumed, not executed.
    assign exec = instr_valid && !flush_reg;
    assign dest_file = instr_word[`IOMB_DEST_BIT];
    assign sets_zero = op == IOMB_OP_ORLIT || op == IOMB_OP_INC ||
                       op == IOMB_OP_ORREG || op == IOMB_OP_MOVE;

    assign a.op = op;
    assign a.acc = acc_reg;
    assign a.fdata = file_rd_data;
    assign a.lit = instr_word[`IOMB_LIT_HI:0];

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_reg <= `IOMB_ACC_RST;
        end else if (exec && (op == IOMB_OP_ORLIT ||
                     (iomb_uses_file(op) && !dest_file))) begin
            acc_reg <= a.result;
        end
    end

    // Skip and branch never touch the flag.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            zero_reg <= 1'b0;
        end else if (exec && sets_zero) begin
            zero_reg <= a.zero;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            file_wr_en_reg <= 1'b0;
            file_wr_addr_reg <= 7'h00;
            file_wr_data_reg <= 8'h00;
        end else begin
            file_wr_en_reg <= exec && iomb_uses_file(op) && dest_file;
            file_wr_addr_reg <= instr_word[`IOMB_FILE_HI:0];
            file_wr_data_reg <= a.result;
        end
    end

    // Taken skips and branches each give up exactly one following slot.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            flush_reg <= 1'b0;
            flush_hold_pc_reg <= 1'b0;
        end else if (exec && (op == IOMB_OP_BRANCH ||
                     (op == IOMB_OP_INCSKIP && a.zero))) begin
            flush_reg <= 1'b1;
            flush_hold_pc_reg <= op == IOMB_OP_BRANCH;
        end else if (instr_valid) begin
            flush_reg <= 1'b0;
            flush_hold_pc_reg <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            slot_nop_reg <= 1'b0;
        end else begin
            slot_nop_reg <= instr_valid && flush_reg;
        end
    end

    // The slot after a branch leaves the target in place for its fetch.
    always_comb begin
        pc_next = pc_reg;
        if (exec && op == IOMB_OP_BRANCH) begin
            pc_next = {pc_page_latch[`IOMB_PAGE_HI:`IOMB_PAGE_LO],
                       instr_word[`IOMB_TARGET_HI:0]};
        end else if (exec || (instr_valid && !flush_hold_pc_reg)) begin
            pc_next = 13'(pc_reg + `IOMB_PC_STEP);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_reg <= `IOMB_PC_RST;
        end else begin
            pc_reg <= pc_next;
        end
    end

    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_skip_keeps_flag: assert property (
        exec && op == IOMB_OP_INCSKIP |=> $stable(zero_reg))
        else $error("skip changed the zero flag");

    a_skip_flushes_next: assert property (
        exec && op == IOMB_OP_INCSKIP && a.zero ##1 instr_valid
        |=> slot_nop_reg && !file_wr_en_reg)
        else $error("slot after zero skip was executed");

    a_skip_no_flush: assert property (
        exec && op == IOMB_OP_INCSKIP && !a.zero |=> !flush_reg)
        else $error("nonzero skip flushed the next slot");

    a_branch_target: assert property (
        exec && op == IOMB_OP_BRANCH |=>
        pc_reg == {$past(pc_page_latch[4:3]), $past(instr_word[10:0])})
        else $error("branch target wrong");

    a_branch_two_cycles: assert property (
        exec && op == IOMB_OP_BRANCH ##1 instr_valid
        |=> slot_nop_reg && $stable(pc_reg) && $stable(zero_reg))
        else $error("branch did not take two cycles");

    a_orlit_result: assert property (
        exec && op == IOMB_OP_ORLIT |=>
        acc_reg == ($past(acc_reg) | $past(instr_word[7:0])))
        else $error("literal OR wrong");

    a_inc_to_file: assert property (
        exec && op == IOMB_OP_INC && dest_file |=> file_wr_en_reg &&
        file_wr_data_reg == 8'($past(file_rd_data) + 8'h01))
        else $error("increment to file wrong");

    a_orreg_to_acc: assert property (
        exec && op == IOMB_OP_ORREG && !dest_file |=> !file_wr_en_reg &&
        acc_reg == ($past(acc_reg) | $past(file_rd_data)))
        else $error("register OR to accumulator wrong");

    a_move_zero_test: assert property (
        exec && op == IOMB_OP_MOVE |=>
        zero_reg == ($past(file_rd_data) == 8'h00))
        else $error("move did not set zero flag");

    a_move_one_cycle: assert property (
        exec && op == IOMB_OP_MOVE |=> !flush_reg &&
        pc_reg == 13'($past(pc_reg) + 13'h0001))
        else $error("move took more than one cycle");

    a_skip_to_file: assert property (
        exec && op == IOMB_OP_INCSKIP && dest_file |=> file_wr_en_reg &&
        file_wr_data_reg == 8'($past(file_rd_data) + 8'h01))
        else $error("skip result to file wrong");

    a_discard_no_effect: assert property (
        instr_valid && flush_reg |=> slot_nop_reg && !file_wr_en_reg &&
        $stable(acc_reg) && $stable(zero_reg))
        else $error("discarded slot had an effect");

    a_gap_keeps_flush: assert property (
        !instr_valid && flush_reg |=> flush_reg && $stable(pc_reg))
        else $error("gap consumed the pending no-op");

    a_orlit_zero: assert property (
        exec && op == IOMB_OP_ORLIT |=>
        zero_reg == (($past(acc_reg) | $past(instr_word[7:0])) == 8'h00))
        else $error("literal OR zero flag wrong");

    a_inc_to_acc: assert property (
        exec && op == IOMB_OP_INC && !dest_file |=> !file_wr_en_reg &&
        acc_reg == 8'($past(file_rd_data) + 8'h01) &&
        zero_reg == ($past(file_rd_data) == 8'hff))
        else $error("increment to accumulator wrong");

    a_orreg_to_file: assert property (
        exec && op == IOMB_OP_ORREG && dest_file |=> file_wr_en_reg &&
        file_wr_data_reg == ($past(acc_reg) | $past(file_rd_data)) &&
        $stable(acc_reg))
        else $error("register OR to file wrong");

    a_move_to_file: assert property (
        exec && op == IOMB_OP_MOVE && dest_file |=> file_wr_en_reg &&
        file_wr_data_reg == $past(file_rd_data) && $stable(acc_reg))
        else $error("move to file wrong");

    a_write_address: assert property (
        file_wr_en_reg |-> file_wr_addr_reg == $past(instr_word[6:0]))
        else $error("file write address wrong");

    c_skip_taken: cover property (exec && op == IOMB_OP_INCSKIP && a.zero);
    c_branch: cover property (exec && op == IOMB_OP_BRANCH ##1 instr_valid);
    c_move_self: cover property (exec && op == IOMB_OP_MOVE && dest_file);
    c_orlit_zero: cover property (exec && op == IOMB_OP_ORLIT && a.zero);
    c_flush_gap: cover property (!instr_valid && flush_reg);

endmodule : iomb_exec

// file: src/iomb_pkg.sv
// Types and shared decode for the execution block.
// Assumes iomb_consts.svh is on the include path.
`include "iomb_consts.svh"

package iomb_pkg;

    typedef enum logic [2:0] {
        IOMB_OP_NONE,
        IOMB_OP_INCSKIP,
        IOMB_OP_BRANCH,
        IOMB_OP_ORLIT,
        IOMB_OP_INC,
        IOMB_OP_ORREG,
        IOMB_OP_MOVE
    } iomb_op_t;

    function automatic iomb_op_t iomb_decode(input logic [13:0] w);
        iomb_op_t op;
        op = IOMB_OP_NONE;
        if (w[`IOMB_OPC_HI:`IOMB_BRA_OPC_LO] == `IOMB_OPC_BRANCH) begin
            op = IOMB_OP_BRANCH;
        end else begin
            case (w[`IOMB_OPC_HI:`IOMB_OPC_LO])
                `IOMB_OPC_INCSKIP: op = IOMB_OP_INCSKIP;
                `IOMB_OPC_INC: op = IOMB_OP_INC;
                `IOMB_OPC_ORREG: op = IOMB_OP_ORREG;
                `IOMB_OPC_MOVE: op = IOMB_OP_MOVE;
                `IOMB_OPC_ORLIT: op = IOMB_OP_ORLIT;
                default: op = IOMB_OP_NONE;
            endcase
        end
        return op;
    endfunction : iomb_decode

    function automatic logic iomb_is_zero(input logic [7:0] v);
        return v == 8'h00;
    endfunction : iomb_is_zero

    function automatic logic iomb_uses_file(input iomb_op_t op);
        return op == IOMB_OP_INCSKIP || op == IOMB_OP_INC ||
               op == IOMB_OP_ORREG || op == IOMB_OP_MOVE;
    endfunction : iomb_uses_file

endpackage : iomb_pkg

// file: tb/incr_or_move_branch_exec_tb.sv
// Self-checking bench for the increment, OR, move and branch executor.
// Assumes the bench plays the register file and the page latch itself.
`timescale 1ns/1ps
`include "iomb_consts.svh"

module incr_or_move_branch_exec_tb;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic instr_valid = 1'b0;
    logic [13:0] instr_word = 14'h0000;
    logic [7:0] file_rd_data = 8'h00;
    logic [7:0] pc_page_latch = 8'h00;
    logic [7:0] acc_reg;
    logic zero_reg;
    logic [12:0] pc_reg;
    logic file_wr_en_reg;
    logic [6:0] file_wr_addr_reg;
    logic [7:0] file_wr_data_reg;
    logic slot_nop_reg;
    logic [12:0] exp_pc = 13'h0000;
    int mismatches = 0;
    int check_count = 0;

    iomb_exec DUT (.ref_clk(ref_clk), .rst_n(rst_n),
        .instr_valid(instr_valid), .instr_word(instr_word),
        .file_rd_data(file_rd_data), .pc_page_latch(pc_page_latch),
        .acc_reg(acc_reg), .zero_reg(zero_reg), .pc_reg(pc_reg),
        .file_wr_en_reg(file_wr_en_reg),
        .file_wr_addr_reg(file_wr_addr_reg),
        .file_wr_data_reg(file_wr_data_reg), .slot_nop_reg(slot_nop_reg));

    always #5 ref_clk = ~ref_clk;

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [12:0] got, input logic [12:0] exp,
                       input string m);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    // Mode 0 steps the pc, 1 is a branch target, 2 holds it.
    // Inputs change at the falling edge so the rising edge sees them settled.
    task automatic run(input logic [13:0] w, input logic [7:0] fd, input int pm);
        instr_valid = 1'b1;
        instr_word = w;
        file_rd_data = fd;
        @(posedge ref_clk);
        @(negedge ref_clk);
        exp_pc = pm == 1 ? {pc_page_latch[4:3], w[10:0]} :
                 pm == 2 ? exp_pc : exp_pc + 13'h0001;
        chk(pc_reg, exp_pc, "pc");
    endtask : run

    task automatic idle;
        instr_valid = 1'b0;
        @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : idle

    task automatic t_orlit;
        run(14'h0000, 8'h00, 0);
        chk(acc_reg, 8'h00, "unknown op acc");
        run({`IOMB_OPC_ORLIT, 8'h00}, 8'h5a, 0);
        chk(zero_reg, 1'b1, "orlit zero");
        run({`IOMB_OPC_ORLIT, 8'ha5}, 8'h00, 0);
        chk(acc_reg, 8'ha5, "orlit acc");
        chk(zero_reg, 1'b0, "orlit nonzero");
        chk(file_wr_en_reg, 1'b0, "orlit no write");
        $display("test orlit done");
    endtask : t_orlit

    task automatic t_inc_or;
        run({`IOMB_OPC_INC, 1'b0, 7'h00}, 8'hff, 0);
        chk(acc_reg, 8'h00, "inc acc");
        chk(zero_reg, 1'b1, "inc zero");
        run({`IOMB_OPC_INC, 1'b1, 7'h7f}, 8'h7f, 0);
        chk(file_wr_en_reg, 1'b1, "inc write");
        chk(file_wr_addr_reg, 7'h7f, "inc addr");
        chk(file_wr_data_reg, 8'h80, "inc data");
        chk(acc_reg, 8'h00, "inc acc kept");
        run({`IOMB_OPC_ORLIT, 8'h0f}, 8'h00, 0);
        run({`IOMB_OPC_ORREG, 1'b1, 7'h15}, 8'hf0, 0);
        chk(file_wr_data_reg, 8'hff, "orreg data");
        chk(acc_reg, 8'h0f, "orreg acc kept");
        run({`IOMB_OPC_ORREG, 1'b0, 7'h15}, 8'h30, 0);
        chk(acc_reg, 8'h3f, "orreg acc");
        chk(file_wr_en_reg, 1'b0, "orreg no write");
        $display("test inc and or done");
    endtask : t_inc_or

    task automatic t_move;
        run({`IOMB_OPC_MOVE, 1'b1, 7'h33}, 8'h00, 0);
        chk(zero_reg, 1'b1, "move self zero");
        chk(file_wr_data_reg, 8'h00, "move self data");
        chk(file_wr_en_reg, 1'b1, "move self write");
        chk(file_wr_addr_reg, 7'h33, "move self addr");
        run({`IOMB_OPC_MOVE, 1'b0, 7'h00}, 8'h3c, 0);
        chk(acc_reg, 8'h3c, "move acc");
        chk(zero_reg, 1'b0, "move zero");
        chk(slot_nop_reg, 1'b0, "move no skip");
        $display("test move done");
    endtask : t_move

    task automatic t_skip;
        run({`IOMB_OPC_INCSKIP, 1'b0, 7'h01}, 8'hfe, 0);
        chk(acc_reg, 8'hff, "skip acc");
        run({`IOMB_OPC_MOVE, 1'b0, 7'h00}, 8'h11, 0);
        chk(acc_reg, 8'h11, "after nonzero");
        run({`IOMB_OPC_INCSKIP, 1'b1, 7'h02}, 8'hff, 0);
        chk(file_wr_data_reg, 8'h00, "skip data");
        chk(file_wr_en_reg, 1'b1, "skip write");
        chk(zero_reg, 1'b0, "skip flags");
        run({`IOMB_OPC_MOVE, 1'b0, 7'h00}, 8'h00, 0);
        chk(slot_nop_reg, 1'b1, "skip nop");
        chk(acc_reg, 8'h11, "skip discard");
        chk(zero_reg, 1'b0, "skip discard zero");
        $display("test skip done");
    endtask : t_skip

    task automatic t_branch;
        pc_page_latch = 8'h18;
        run({`IOMB_OPC_BRANCH, 11'h7ff}, 8'h00, 1);
        idle();
        run({`IOMB_OPC_MOVE, 1'b0, 7'h00}, 8'h00, 2);
        chk(slot_nop_reg, 1'b1, "branch nop");
        chk(zero_reg, 1'b0, "branch flags");
        pc_page_latch = 8'he7;
        run({`IOMB_OPC_BRANCH, 11'h555}, 8'h00, 1);
        run({`IOMB_OPC_ORLIT, 8'h80}, 8'h00, 2);
        chk(acc_reg, 8'h11, "branch discard");
        run({`IOMB_OPC_MOVE, 1'b0, 7'h00}, 8'h44, 0);
        chk(acc_reg, 8'h44, "after branch");
        $display("test branch done");
    endtask : t_branch

    // A reset in mid-run must also drop a pending no-op slot.
    task automatic t_reset;
        run({`IOMB_OPC_ORLIT, 8'hff}, 8'h00, 0);
        run({`IOMB_OPC_INCSKIP, 1'b1, 7'h05}, 8'hff, 0);
        instr_valid = 1'b0;
        rst_n = 1'b0;
        #1;
        chk(acc_reg, 8'h00, "midrun reset acc");
        chk(pc_reg, 13'h0000, "midrun reset pc");
        @(negedge ref_clk);
        rst_n = 1'b1;
        exp_pc = 13'h0000;
        run({`IOMB_OPC_MOVE, 1'b0, 7'h00}, 8'h22, 0);
        chk(slot_nop_reg, 1'b0, "reset clears skip");
        chk(acc_reg, 8'h22, "after reset move");
        $display("test reset done");
    endtask : t_reset

    initial begin
        repeat (1000) @(posedge ref_clk);
        mismatches++;
        $display("BAD t=%0t watchdog expired", $time);
        report_and_stop();
    end

    initial begin
        repeat (16) @(posedge ref_clk);
        @(negedge ref_clk);
        chk(pc_reg, 13'h0000, "reset pc");
        chk(acc_reg, 8'h00, "reset acc");
        chk(file_wr_en_reg, 1'b0, "reset write");
        chk(zero_reg, 1'b0, "reset zero");
        chk(slot_nop_reg, 1'b0, "reset nop");
        rst_n = 1'b1;
        t_orlit();
        t_inc_or();
        t_move();
        t_skip();
        t_branch();
        t_reset();
        report_and_stop();
    end
endmodule : incr_or_move_branch_exec_tb
